// >>> design/mtt_monitor_regs.sv
// monitor setup, message pointers and time tag register block
//
// How it works
// (RULE_01) setup bit 2 set: extended flags land in reserved status word bits.
// (RULE_02) setup bit 2 clear: only standard status word flags are recorded.
// (RULE_03) setup bit 1 clear: 16-bit count, four words per message entry.
// (RULE_04) setup bit 1 set: 48-bit count, eight words per message entry.
// (RULE_05) host sets setup bit 0 to choose simple monitor operation.
// (RULE_06) list base register is read/write, resets to 0x00B0.
// (RULE_07) list base keeps its value across monitor soft reset.
// (RULE_08) next pointer is read-only, set at completion, cleared by either reset.
// (RULE_09) next pointer reads zero after reset or base change until completion.
// (RULE_10) last pointer holds first word of last completed message; resets clear it.
// (RULE_11) narrow mode: low count register holds the whole count.
// (RULE_12) wide mode: count spans low, mid and high registers.
// (RULE_13) count registers ignore writes; counter config bits 15-14 command them.
// (RULE_14) a match with the programmed 16/48-bit value raises a pulse.
// (RULE_15) three utility registers are read/write and reset to zero.
// (RULE_16) load copies utility words into the count in one cycle; clear zeroes it.
// (RULE_17) capture copies all count words into utility registers in one cycle.
// (RULE_18) counter adds one per tick and wraps at its width.
// (RULE_19) each command write acts exactly once.
`default_nettype none
module mtt_monitor_regs
    import mtt_pkg::*;
(
    input wire logic clk, // system clock, 200 MHz
    input wire logic rstn, // master reset, synchronous, active low
    input wire mtt_req_t host_req, // host register read/write request
    output logic [15:0] rd_data, // read data, one cycle after rd
    output logic rd_valid, // read data valid pulse
    input wire logic monitor_soft_reset, // monitor soft reset pulse
    input wire logic time_tick, // time base tick pulse
    input wire mtt_msg_t msg, // message completion from monitor engine
    input wire logic [15:0] bsw_raw, // block status word before masking
    input wire logic bsw_valid, // raw status word strobe
    output logic [15:0] bsw_rec, // status word to be recorded
    output logic bsw_rec_valid, // recorded status word strobe
    output logic [3:0] entry_words, // words per command buffer entry
    output logic simple_mode, // simple monitor selected
    output logic wide_stamp, // 48-bit time tag selected
    output logic extended_flag_enable, // extended flags enabled
    output logic stamp_match // count equals match value, pulse
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [15:0] setup_reg, setup_next;
    logic [15:0] base_reg, base_next;
    logic [15:0] nptr_reg, nptr_next;
    logic [15:0] lptr_reg, lptr_next;
    logic [15:0] ttcfg_reg, ttcfg_next;
    logic [47:0] util_reg, util_next;
    logic [47:0] match_reg, match_next;
    logic [15:0] rdat_reg, rdat_next;
    logic rval_reg, rval_next;
    logic [15:0] bsw_reg, bsw_next;
    logic bswv_reg, bswv_next;
    logic [3:0] entry_reg, entry_next;
    logic hit_reg, hit_next;
    logic mpulse_reg, mpulse_next;
    logic [47:0] count;
    logic [47:0] count_view;
    logic [47:0] match_view;
    logic [1:0] cmd;
    logic cmd_clear, cmd_load, cmd_capture;
    logic wide;

    // address hit, used by every write decode; the read port decodes with a case
    function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign wide = setup_reg[MTT_BIT_WIDE];
    // command field of a write to the counter configuration; one action per write
    assign cmd = (host_req.wr && hit(host_req.addr, MTT_OFS_TTCFG)) ?
        host_req.wdata[MTT_CMD_HI:MTT_CMD_LO] : MTT_CMD_NONE; // see (RULE_13) (RULE_19)
    assign cmd_clear = (cmd == MTT_CMD_CLEAR);
    assign cmd_load = (cmd == MTT_CMD_LOAD);
    assign cmd_capture = (cmd == MTT_CMD_CAPTURE);
    // narrow mode shows only the low word; upper words read zero
    assign count_view = wide ? count : {32'h0, count[15:0]}; // see (RULE_11) (RULE_12)
    assign match_view = wide ? match_reg : {32'h0, match_reg[15:0]};

    // ****************************************************************
    // time tag counter
    // ****************************************************************
    mtt_stamp_counter u_counter (
        .clk(clk),
        .rstn(rstn),
        .tick(time_tick),
        .wide(wide),
        .do_clear(cmd_clear),
        .do_load(cmd_load),
        .load_val(util_reg),
        .count(count)
    );

    // ****************************************************************
    // register next values
    // ****************************************************************
    // message completion wins over a base write in the same cycle
    always_comb begin
        setup_next = setup_reg;
        base_next = base_reg;
        nptr_next = nptr_reg;
        lptr_next = lptr_reg;
        ttcfg_next = ttcfg_reg;
        util_next = util_reg;
        match_next = match_reg;
        if (host_req.wr) begin
            if (hit(host_req.addr, MTT_OFS_SETUP)) begin
                setup_next = host_req.wdata; // host sets bit 0 for simple mode, see (RULE_05)
            end
            if (hit(host_req.addr, MTT_OFS_BASE)) begin
                base_next = host_req.wdata; // see (RULE_06)
                nptr_next = MTT_ZERO16; // see (RULE_09)
            end
            if (hit(host_req.addr, MTT_OFS_TTCFG)) begin
                ttcfg_next = host_req.wdata & MTT_TTCFG_WMASK;
            end
            if (hit(host_req.addr, MTT_OFS_UT_LO)) begin
                util_next[15:0] = host_req.wdata; // see (RULE_15)
            end
            if (hit(host_req.addr, MTT_OFS_UT_MID)) begin
                util_next[31:16] = host_req.wdata; // see (RULE_15)
            end
            if (hit(host_req.addr, MTT_OFS_UT_HI)) begin
                util_next[47:32] = host_req.wdata; // see (RULE_15)
            end
            if (hit(host_req.addr, MTT_OFS_MT_LO)) begin
                match_next[15:0] = host_req.wdata;
            end
            if (hit(host_req.addr, MTT_OFS_MT_MID)) begin
                match_next[31:16] = host_req.wdata;
            end
            if (hit(host_req.addr, MTT_OFS_MT_HI)) begin
                match_next[47:32] = host_req.wdata;
            end
            // writes to the count addresses fall through untouched, see (RULE_13)
        end
        if (cmd_capture) begin
            util_next = count_view; // see (RULE_17)
        end
        // soft reset clears pointers only; the base survives, see (RULE_07)
        if (monitor_soft_reset) begin
            nptr_next = MTT_ZERO16; // see (RULE_08)
            lptr_next = MTT_ZERO16; // see (RULE_10)
        end
        if (msg.done) begin
            nptr_next = msg.next_addr; // see (RULE_08)
            lptr_next = msg.first_addr; // see (RULE_10)
        end
    end

    // ****************************************************************
    // read port, status word path, entry size and match
    // ****************************************************************
    // unmapped addresses read zero; read data is always registered
    always_comb begin
        rdat_next = MTT_ZERO16;
        rval_next = host_req.rd;
        if (host_req.rd) begin
            unique case (host_req.addr)
                MTT_OFS_SETUP: rdat_next = setup_reg;
                MTT_OFS_BASE: rdat_next = base_reg;
                MTT_OFS_NEXT: rdat_next = nptr_reg;
                MTT_OFS_LAST: rdat_next = lptr_reg;
                MTT_OFS_TTCFG: rdat_next = ttcfg_reg;
                MTT_OFS_CNT_LO: rdat_next = count_view[15:0]; // see (RULE_11)
                MTT_OFS_CNT_MID: rdat_next = count_view[31:16]; // see (RULE_12)
                MTT_OFS_CNT_HI: rdat_next = count_view[47:32]; // see (RULE_12)
                MTT_OFS_UT_LO: rdat_next = util_reg[15:0];
                MTT_OFS_UT_MID: rdat_next = util_reg[31:16];
                MTT_OFS_UT_HI: rdat_next = util_reg[47:32];
                MTT_OFS_MT_LO: rdat_next = match_reg[15:0];
                MTT_OFS_MT_MID: rdat_next = match_reg[31:16];
                MTT_OFS_MT_HI: rdat_next = match_reg[47:32];
                default: rdat_next = MTT_ZERO16;
            endcase
        end
        // reserved positions are used only with the extended flags on
        bsw_next = setup_reg[MTT_BIT_EXT] ? bsw_raw
            : (bsw_raw & MTT_BSW_DEFINED); // see (RULE_01) (RULE_02)
        bswv_next = bsw_valid;
        entry_next = wide ? MTT_ENTRY_WIDE : MTT_ENTRY_NARROW; // see (RULE_03) (RULE_04)
        // level compare, edge taken so a parked count fires once
        hit_next = (count_view == match_view); // see (RULE_14)
        mpulse_next = hit_next && !hit_reg;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            setup_reg <= MTT_SETUP_RESET;
            base_reg <= MTT_BASE_RESET;
            nptr_reg <= MTT_ZERO16;
            lptr_reg <= MTT_ZERO16;
            ttcfg_reg <= MTT_ZERO16;
            util_reg <= 48'h0;
            match_reg <= 48'h0;
            rdat_reg <= MTT_ZERO16;
            rval_reg <= 1'b0;
            bsw_reg <= MTT_ZERO16;
            bswv_reg <= 1'b0;
            entry_reg <= MTT_ENTRY_NARROW;
            hit_reg <= 1'b1;
            mpulse_reg <= 1'b0;
        end else begin
            setup_reg <= setup_next;
            base_reg <= base_next;
            nptr_reg <= nptr_next;
            lptr_reg <= lptr_next;
            ttcfg_reg <= ttcfg_next;
            util_reg <= util_next;
            match_reg <= match_next;
            rdat_reg <= rdat_next;
            rval_reg <= rval_next;
            bsw_reg <= bsw_next;
            bswv_reg <= bswv_next;
            entry_reg <= entry_next;
            hit_reg <= hit_next;
            mpulse_reg <= mpulse_next;
        end
    end

    assign rd_data = rdat_reg;
    assign rd_valid = rval_reg;
    assign bsw_rec = bsw_reg;
    assign bsw_rec_valid = bswv_reg;
    assign entry_words = entry_reg;
    assign simple_mode = setup_reg[MTT_BIT_TYPE];
    assign wide_stamp = setup_reg[MTT_BIT_WIDE];
    assign extended_flag_enable = setup_reg[MTT_BIT_EXT];
    assign stamp_match = mpulse_reg;

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_base_reset;
        @(posedge clk) !rstn |=> (base_reg == MTT_BASE_RESET);
    endproperty
    a_base_reset: assert property (p_base_reset) // see (RULE_06)
        else $error("base not 0x00B0 after reset");

    property p_base_soft;
        @(posedge clk) disable iff (!rstn)
        (monitor_soft_reset && !host_req.wr) |=> $stable(base_reg);
    endproperty
    a_base_soft: assert property (p_base_soft) // see (RULE_07)
        else $error("base changed by soft reset");

    property p_next_soft;
        @(posedge clk) disable iff (!rstn)
        (monitor_soft_reset && !msg.done) |=> (nptr_reg == 16'h0000) && (lptr_reg == 16'h0000);
    endproperty
    a_next_soft: assert property (p_next_soft) // see (RULE_08)
        else $error("pointers not cleared");

    property p_next_base;
        @(posedge clk) disable iff (!rstn)
        (host_req.wr && hit(host_req.addr, MTT_OFS_BASE) && !msg.done)
        ##1 (!msg.done)[*2] |-> (nptr_reg == 16'h0000);
    endproperty
    a_next_base: assert property (p_next_base) // see (RULE_09)
        else $error("next pointer not zero");

    property p_last_upd;
        @(posedge clk) disable iff (!rstn)
        msg.done |=> (lptr_reg == $past(msg.first_addr)) && (nptr_reg == $past(msg.next_addr));
    endproperty
    a_last_upd: assert property (p_last_upd) // see (RULE_10)
        else $error("pointers not updated");

    property p_count_ro;
        @(posedge clk) disable iff (!rstn)
        (host_req.wr && hit(host_req.addr, MTT_OFS_CNT_LO) && !time_tick) |=> $stable(count);
    endproperty
    a_count_ro: assert property (p_count_ro) // see (RULE_13)
        else $error("count took a direct write");

    property p_narrow;
        @(posedge clk) disable iff (!rstn)
        (!wide && !$past(wide)) |-> (count[47:16] == 32'h0);
    endproperty
    a_narrow: assert property (p_narrow) // see (RULE_03)
        else $error("narrow count exceeds 16 bits");

    property p_load;
        @(posedge clk) disable iff (!rstn)
        (cmd_load && wide) |=> (count == $past(util_reg));
    endproperty
    a_load: assert property (p_load) else $error("load did not copy all words"); // see (RULE_16)

    property p_capture;
        @(posedge clk) disable iff (!rstn)
        cmd_capture |=> (util_reg == $past(count_view));
    endproperty
    a_capture: assert property (p_capture) // see (RULE_17)
        else $error("capture not simultaneous");

    property p_tick;
        @(posedge clk) disable iff (!rstn)
        (time_tick && wide && cmd == MTT_CMD_NONE) |=> (count == $past(count) + 48'h1);
    endproperty
    a_tick: assert property (p_tick) else $error("tick did not add one"); // see (RULE_18)

    property p_bsw;
        @(posedge clk) disable iff (!rstn)
        (bsw_valid && !setup_reg[MTT_BIT_EXT]) |=>
            bsw_rec_valid && ((bsw_rec & ~MTT_BSW_DEFINED) == 16'h0);
    endproperty
    a_bsw: assert property (p_bsw) else $error("reserved flags recorded"); // see (RULE_02)

    property p_entry;
        @(posedge clk) disable iff (!rstn)
        ##1 $stable(wide) |-> (entry_words == (wide ? MTT_ENTRY_WIDE : MTT_ENTRY_NARROW));
    endproperty
    a_entry: assert property (p_entry) else $error("entry size mismatch"); // see (RULE_04)

    property p_match;
        @(posedge clk) disable iff (!rstn)
        stamp_match |-> ($past(count_view) == $past(match_view));
    endproperty
    a_match: assert property (p_match) // see (RULE_14)
        else $error("match pulse without equality");

    c_load: cover property (@(posedge clk) disable iff (!rstn) cmd_load && wide);
    c_capture: cover property (@(posedge clk) disable iff (!rstn) cmd_capture);
    c_msg: cover property (@(posedge clk) disable iff (!rstn) msg.done ##1 monitor_soft_reset);
    c_match: cover property (@(posedge clk) disable iff (!rstn) stamp_match);
endmodule
`default_nettype wire

// >>> design/mtt_pkg.sv
// package: offsets, fields, reset values and carriers of the monitor time tag block
`default_nettype none
package mtt_pkg;
    // ****************************************************************
    // register offsets (word addresses on the host register port)
    // ****************************************************************
    localparam logic [15:0] MTT_OFS_SETUP = 16'h0028;
    localparam logic [15:0] MTT_OFS_BASE = 16'h002F;
    localparam logic [15:0] MTT_OFS_NEXT = 16'h0030;
    localparam logic [15:0] MTT_OFS_LAST = 16'h0031;
    localparam logic [15:0] MTT_OFS_TTCFG = 16'h0039;
    localparam logic [15:0] MTT_OFS_CNT_LO = 16'h003A;
    localparam logic [15:0] MTT_OFS_CNT_MID = 16'h003B;
    localparam logic [15:0] MTT_OFS_CNT_HI = 16'h003C;
    localparam logic [15:0] MTT_OFS_UT_LO = 16'h003D;
    localparam logic [15:0] MTT_OFS_UT_MID = 16'h003E;
    localparam logic [15:0] MTT_OFS_UT_HI = 16'h003F;
    localparam logic [15:0] MTT_OFS_MT_LO = 16'h0040;
    localparam logic [15:0] MTT_OFS_MT_MID = 16'h0041;
    localparam logic [15:0] MTT_OFS_MT_HI = 16'h0042;

    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int MTT_BIT_TYPE = 0;
    localparam int MTT_BIT_WIDE = 1;
    localparam int MTT_BIT_EXT = 2;
    localparam int MTT_CMD_HI = 15;
    localparam int MTT_CMD_LO = 14;
    localparam logic [15:0] MTT_SETUP_RESET = 16'h0000;
    localparam logic [15:0] MTT_BASE_RESET = 16'h00B0;
    localparam logic [15:0] MTT_ZERO16 = 16'h0000;
    localparam logic [15:0] MTT_TTCFG_WMASK = 16'h3FFF;
    // flags the standard block status word defines; the rest are extended
    localparam logic [15:0] MTT_BSW_DEFINED = 16'hC0FF;
    // time tag command encodings of the counter configuration field
    localparam logic [1:0] MTT_CMD_NONE = 2'h0;
    localparam logic [1:0] MTT_CMD_CLEAR = 2'h1;
    localparam logic [1:0] MTT_CMD_CAPTURE = 2'h2;
    localparam logic [1:0] MTT_CMD_LOAD = 2'h3;
    localparam logic [3:0] MTT_ENTRY_NARROW = 4'h4;
    localparam logic [3:0] MTT_ENTRY_WIDE = 4'h8;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mtt_req_t;

    typedef struct packed {
        logic done;
        logic [15:0] first_addr;
        logic [15:0] next_addr;
    } mtt_msg_t;
endpackage
`default_nettype wire

// >>> design/mtt_stamp_counter.sv
// time tag counter: 16 or 48 bits, clear, load and tick
`default_nettype none
module mtt_stamp_counter
    import mtt_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic tick, // one-cycle time base pulse
    input wire logic wide, // 48-bit mode
    input wire logic do_clear, // clear pulse
    input wire logic do_load, // load pulse
    input wire logic [47:0] load_val, // value from the utility triplet
    output logic [47:0] count // current count
);
    logic [47:0] cnt_reg;
    logic [47:0] cnt_next;
    logic [15:0] low_inc;

    // ****************************************************************
    // next count
    // ****************************************************************
    // clear and load win over a tick in the same cycle, so the host value is exact
    always_comb begin
        low_inc = cnt_reg[15:0] + 16'h0001;
        // narrow mode drops the upper words, so a switch from wide never leaves stale bits
        cnt_next = wide ? cnt_reg : {32'h0, cnt_reg[15:0]}; // see (RULE_03)
        if (do_clear) begin
            cnt_next = 48'h0; // see (RULE_16)
        end else if (do_load) begin
            // all three words land on one edge, never torn
            cnt_next = wide ? load_val : {32'h0, load_val[15:0]}; // see (RULE_16)
        end else if (tick) begin
            if (wide) begin
                cnt_next = cnt_reg + 48'h1; // see (RULE_04) (RULE_18)
            end else begin
                cnt_next = {32'h0, low_inc}; // see (RULE_03) (RULE_18)
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg <= 48'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign count = cnt_reg;
endmodule
`default_nettype wire

// >>> verification/mtt_engine_model.sv
// monitor engine model: message completions with command buffer addresses
`default_nettype none
module mtt_engine_model
    import mtt_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic go, // bench asks for one completion
    input wire logic [15:0] base, // command buffer start
    input wire logic [3:0] entry_words, // words per entry from the block
    output var mtt_msg_t msg // completion towards the block
);
    logic [15:0] offset_reg;
    logic [15:0] offset_next;
    mtt_msg_t msg_next;
    // ****************************************************************
    // entry stepping
    // ****************************************************************
    // idle addresses flip each cycle so a stale value is never mistaken for live data
    always_comb begin
        offset_next = go ? offset_reg + {12'h0, entry_words} : offset_reg;
        msg_next.done = go;
        msg_next.first_addr = go ? base + offset_reg : ~msg.first_addr;
        msg_next.next_addr = go ? base + offset_next : ~msg.next_addr;
    end
    // registers only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            offset_reg <= 16'h0000;
            msg <= '0;
        end else begin
            offset_reg <= offset_next;
            msg <= msg_next;
        end
    end
endmodule
`default_nettype wire

// >>> verification/mtt_monitor_regs_bench.sv
// self-checking bench of the monitor time tag register block
`default_nettype none
module mtt_monitor_regs_bench;
    import mtt_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rstn = 1'b0, srst = 1'b0, tick = 1'b0, bsw_valid = 1'b0, go = 1'b0;
    mtt_req_t req = '0;
    mtt_msg_t msg;
    logic [15:0] rd_data, bsw_rec, bsw_raw = 16'h0000, base_val = 16'h1234;
    logic rd_valid, bsw_rec_valid, simple_mode, wide_stamp, ext_en, stamp_match, hit;
    logic [3:0] entry_words;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    logic [15:0] ra [8] = '{MTT_OFS_BASE, MTT_OFS_NEXT, MTT_OFS_LAST, MTT_OFS_UT_LO,
        MTT_OFS_UT_MID, MTT_OFS_UT_HI, MTT_OFS_CNT_LO, 16'h0050};
    logic [15:0] re [8] = '{16'h00B0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000};
    mtt_monitor_regs DUT (.clk(clk), .rstn(rstn), .host_req(req), .rd_data(rd_data),
        .rd_valid(rd_valid), .monitor_soft_reset(srst), .time_tick(tick), .msg(msg),
        .bsw_raw(bsw_raw), .bsw_valid(bsw_valid), .bsw_rec(bsw_rec),
        .bsw_rec_valid(bsw_rec_valid), .entry_words(entry_words), .simple_mode(simple_mode),
        .wide_stamp(wide_stamp), .extended_flag_enable(ext_en), .stamp_match(stamp_match));
    mtt_engine_model engine (.clk(clk), .rstn(rstn), .go(go), .base(base_val),
        .entry_words(entry_words), .msg(msg));
    // ****************************************************************
    // clock, watchdog and shared tasks
    // ****************************************************************
    always #2.5 clk = ~clk;
    // ceiling well above the roughly 130 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // each access starts one edge later so no strobe is set and cleared in one step
    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge clk);
        #1 req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge clk);
        #1 req.wr = 1'b0;
    endtask
    task automatic rd(logic [15:0] a, logic [15:0] e);
        @(posedge clk);
        #1 req.rd = 1'b1;
        req.addr = a;
        @(posedge clk);
        #1 req.rd = 1'b0;
        chk("rd_valid", {15'h0, rd_valid}, 16'h0001);
        chk("rd_data", rd_data, e);
    endtask
    task automatic ticks(int n);
        repeat (n) begin
            @(posedge clk);
            #1 tick = 1'b1;
            @(posedge clk);
            #1 tick = 1'b0;
        end
    endtask
    task automatic status(logic [15:0] e);
        @(posedge clk);
        #1 bsw_raw = 16'hFFFF;
        bsw_valid = 1'b1;
        @(posedge clk);
        #1 bsw_valid = 1'b0;
        chk("bsw_rec_valid", {15'h0, bsw_rec_valid}, 16'h0001);
        chk("bsw_rec", bsw_rec, e);
    endtask
    task automatic message();
        @(posedge clk);
        #1 go = 1'b1;
        @(posedge clk);
        #1 go = 1'b0;
        @(posedge clk);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        foreach (ra[i]) rd(ra[i], re[i]);
        chk("entry", {12'h0, entry_words}, 16'h0004);
        wr(MTT_OFS_BASE, base_val);
        rd(MTT_OFS_BASE, base_val);
        wr(MTT_OFS_NEXT, 16'h5555);
        rd(MTT_OFS_NEXT, 16'h0000);
        // narrow stamp, simple monitor selected by the host
        wr(MTT_OFS_SETUP, 16'h0001);
        chk("simple", {15'h0, simple_mode}, 16'h0001);
        ticks(3);
        rd(MTT_OFS_CNT_LO, 16'h0003);
        wr(MTT_OFS_CNT_LO, 16'h5555);
        rd(MTT_OFS_CNT_LO, 16'h0003);
        rd(MTT_OFS_CNT_MID, 16'h0000);
        wr(MTT_OFS_UT_LO, 16'hFFFF);
        wr(MTT_OFS_TTCFG, 16'hC000);
        ticks(1);
        rd(MTT_OFS_CNT_LO, 16'h0000);
        rd(MTT_OFS_TTCFG, 16'h0000);
        // wide stamp: carry through all three words
        wr(MTT_OFS_SETUP, 16'h0003);
        chk("wide", {15'h0, wide_stamp}, 16'h0001);
        wr(MTT_OFS_UT_MID, 16'hFFFF);
        // entry size follows the setup bit one cycle later
        chk("entry", {12'h0, entry_words}, 16'h0008);
        wr(MTT_OFS_UT_HI, 16'h0001);
        wr(MTT_OFS_TTCFG, 16'hC000);
        ticks(1);
        rd(MTT_OFS_CNT_LO, 16'h0000);
        rd(MTT_OFS_CNT_MID, 16'h0000);
        rd(MTT_OFS_CNT_HI, 16'h0002);
        wr(MTT_OFS_TTCFG, 16'h8000);
        rd(MTT_OFS_UT_LO, 16'h0000);
        rd(MTT_OFS_UT_HI, 16'h0002);
        wr(MTT_OFS_TTCFG, 16'h4000);
        rd(MTT_OFS_CNT_HI, 16'h0000);
        // match on a low count value
        wr(MTT_OFS_MT_LO, 16'h0003);
        ticks(3);
        hit = 1'b0;
        repeat (6) begin
            @(posedge clk);
            #1 hit = hit | stamp_match;
        end
        chk("match", {15'h0, hit}, 16'h0001);
        status(MTT_BSW_DEFINED);
        wr(MTT_OFS_SETUP, 16'h0007);
        chk("ext", {15'h0, ext_en}, 16'h0001);
        rd(MTT_OFS_SETUP, 16'h0007);
        status(16'hFFFF);
        // completions, soft reset and base change
        message();
        message();
        rd(MTT_OFS_NEXT, 16'h1244);
        rd(MTT_OFS_LAST, 16'h123C);
        @(posedge clk);
        #1 srst = 1'b1;
        @(posedge clk);
        #1 srst = 1'b0;
        rd(MTT_OFS_NEXT, 16'h0000);
        rd(MTT_OFS_LAST, 16'h0000);
        rd(MTT_OFS_BASE, 16'h1234);
        message();
        wr(MTT_OFS_BASE, 16'h2000);
        rd(MTT_OFS_NEXT, 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire
